// ==== hw/digital_io_line_config.sv ====
// Purpose: six-line digital i/o port with per-line function and edge setup
// Assumes: status inputs are on core_clk_i; pins are asynchronous
// Notes:   Avalon-MM slave, one wait cycle per access
// Notes on behaviour
// - six lines, index one to six, each with own function and edge
// - reset: lines 1 and 3 hardwired, others software read of the pin
// - hardwired function accepted only on lines 1 and 3
// - hardwired line 1 is a trigger input on rise, fall or either edge
// - hardwired line 3 pulses 10 us on protection trip or reversed sense
// - event input on lines 2,4,5,6: enable, disable, begin, halt (begin and halt accepted only while in cell tester mode); default enable
// - event output on lines 2,4,5,6: conditions or fixed level; default high
// - battery full and depleted outputs accepted only while in battery emulation mode
// - regulation mode and sequence finished outputs accepted only while in cell tester mode
// - software function on every line: drive high, drive low, read pin
// - per-line edge polarity, default rising, for event input and output
//
// The Avalon-MM slave port and the address map were decided locally.
`include "dio_cfg.svh"

module digital_io_line_config (
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  input  wire dio_pkg::avl_req_t   avl_i,
  output logic [31:0]              avl_readdata_o,
  output logic                     avl_waitrequest_o,
  input  wire logic                protection_trip_i,
  input  wire logic                sense_reversed_i,
  input  wire logic                battery_full_i,
  input  wire logic                battery_depleted_i,
  input  wire logic                regulation_mode_flag_i,
  input  wire logic                sequence_done_i,
  input  wire logic                source_state_flag_i,
  input  wire logic [5:0]          pin_i,
  output logic [5:0]               pin_o,
  output logic [5:0]               pin_oe_o,
  output logic                     trigger_pulse_o,
  output dio_pkg::in_pulse_t       in_pulse_o
);
  import dio_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  line_cfg_t  line_cfg [6];
  mode_t      op_mode;
  trig_sel_t  trig_sel;
  logic       reject;
  logic [5:0] pin_now;
  logic [5:0] pin_prev;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic       trip_prev;
  logic       prot_on;
  logic [8:0] prot_cnt;
  logic       acc_w;
  logic       acc_r;
  logic [2:0] widx;
  logic       cfg_hit;
  line_cfg_t  wcfg;
  logic       cfg_ok;
  in_pulse_t  next_in_pulse;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic cfg_legal(input logic [2:0] idx, input line_cfg_t c,
                                     input mode_t m);
    logic hw_line;
    hw_line = (idx == 3'h0) || (idx == 3'h2);
    cfg_legal = 1'b0;
    case (c.func)
      fn_hardwired: cfg_legal = hw_line;
      fn_event_in: begin
        if (!hw_line && c.act <= in_halt_sequence) begin
          cfg_legal = (c.act < in_begin_sequence) || (m == cell_tester_mode);
        end
      end
      fn_event_out: begin
        if (!hw_line && c.act <= out_source_state_flag) begin
          if (c.act == out_battery_full || c.act == out_battery_depleted) begin
            cfg_legal = (m == battery_emulation_mode);
          end else if (c.act == out_regulation_mode_flag
                       || c.act == out_sequence_finished) begin
            cfg_legal = (m == cell_tester_mode);
          end else begin
            cfg_legal = 1'b1;
          end
        end
      end
      default: cfg_legal = (c.act <= sw_software_drive_low);
    endcase
  endfunction

  function automatic logic active_edge(input edge_t p, input logic r, input logic f);
    active_edge = (p == edge_rise) ? r : f;
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign acc_w   = avl_i.write && !avl_waitrequest_o;
  assign acc_r   = (avl_i.read || avl_i.write) && avl_waitrequest_o;
  assign widx    = avl_i.address[4:2];
  assign cfg_hit = (avl_i.address <= `OFS_LINE_LAST) && (avl_i.address[1:0] == 2'h0);
  assign wcfg    = line_cfg_t'(avl_i.writedata[`FLD_CFG_MSB:`FLD_CFG_LSB]);
  assign cfg_ok  = cfg_legal(widx, wcfg, op_mode);

  // one wait cycle, then the answer; keeps the read mux out of the bus path
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      avl_waitrequest_o <= 1'b1;
    end else if (acc_r) begin
      avl_waitrequest_o <= 1'b0;
    end else begin
      avl_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      avl_readdata_o <= 32'h0000_0000;
    end else if (acc_r) begin
      if (cfg_hit) begin
        avl_readdata_o <= {26'h0, line_cfg[widx]};
      end else if (avl_i.address == `OFS_MODE) begin
        avl_readdata_o <= {28'h0, trig_sel, op_mode};
      end else if (avl_i.address == `OFS_PINS) begin
        avl_readdata_o <= {26'h0, pin_now};
      end else if (avl_i.address == `OFS_STAT) begin
        avl_readdata_o <= {31'h0, reject};
      end else begin
        avl_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 6; i++) begin
        line_cfg[i] <= (i == 0 || i == 2) ? `RST_CFG_HW : `RST_CFG_SW;
      end
    end else if (acc_w && cfg_hit && avl_i.byteenable[0] && cfg_ok) begin
      line_cfg[widx] <= wcfg;
    end
  end

  // mode changes leave lines alone; the gate acts when a line is written
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      op_mode  <= mode_t'(`RST_MODE);
      trig_sel <= trig_sel_t'(`RST_TRIG);
    end else if (acc_w && avl_i.address == `OFS_MODE && avl_i.byteenable[0]
                 && avl_i.writedata[`FLD_MODE_MSB:`FLD_MODE_LSB] != 2'h3
                 && avl_i.writedata[`FLD_TRIG_MSB:`FLD_TRIG_LSB] != 2'h3) begin
      op_mode  <= mode_t'(avl_i.writedata[`FLD_MODE_MSB:`FLD_MODE_LSB]);
      trig_sel <= trig_sel_t'(avl_i.writedata[`FLD_TRIG_MSB:`FLD_TRIG_LSB]);
    end
  end

  // sticky reject flag, write one to clear; a new reject wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reject <= 1'b0;
    end else if (acc_w && cfg_hit && avl_i.byteenable[0] && !cfg_ok) begin
      reject <= 1'b1;
    end else if (acc_w && avl_i.address == `OFS_STAT
                 && avl_i.writedata[`FLD_REJECT]) begin
      reject <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  dio_pin_sync u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (pin_i),
    .stable_o   (pin_now)
  );

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_prev <= 6'h00;
    end else begin
      pin_prev <= pin_now;
    end
  end

  assign pin_rise = pin_now & ~pin_prev;
  assign pin_fall = ~pin_now & pin_prev;

  // ----------------------------------------
  // line 1 trigger and event inputs
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trigger_pulse_o <= 1'b0;
    end else if (line_cfg[0].func == fn_hardwired) begin
      case (trig_sel)
        trig_rise: trigger_pulse_o <= pin_rise[0];
        trig_fall: trigger_pulse_o <= pin_fall[0];
        default:   trigger_pulse_o <= pin_rise[0] | pin_fall[0];
      endcase
    end else begin
      trigger_pulse_o <= 1'b0;
    end
  end

  always_comb begin
    next_in_pulse = '0;
    for (int i = 0; i < 6; i++) begin
      if (line_cfg[i].func == fn_event_in
          && active_edge(line_cfg[i].pol, pin_rise[i], pin_fall[i])) begin
        case (line_cfg[i].act)
          in_enable_source_output:  next_in_pulse.enable_source_output  = 1'b1;
          in_disable_source_output: next_in_pulse.disable_source_output = 1'b1;
          in_begin_sequence:        next_in_pulse.begin_sequence        = 1'b1;
          default:                  next_in_pulse.halt_sequence         = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      in_pulse_o <= '0;
    end else begin
      in_pulse_o <= next_in_pulse;
    end
  end

  // ----------------------------------------
  // protection pulse on line 3
  // ----------------------------------------
  // one pulse per trip; trips during a pulse are not stretched
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trip_prev <= 1'b0;
      prot_on   <= 1'b0;
      prot_cnt  <= 9'h000;
    end else begin
      trip_prev <= protection_trip_i | sense_reversed_i;
      if (prot_on) begin
        if (prot_cnt == 9'h000) begin
          prot_on <= 1'b0;
        end else begin
          prot_cnt <= prot_cnt - 9'h001;
        end
      end else if ((protection_trip_i | sense_reversed_i) && !trip_prev
                   && line_cfg[2].func == fn_hardwired) begin
        prot_on  <= 1'b1;
        prot_cnt <= `PULSE_CYC - 9'h001;
      end
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_o    <= 6'h00;
      pin_oe_o <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        pin_o[i]    <= 1'b0;
        pin_oe_o[i] <= 1'b0;
        case (line_cfg[i].func)
          fn_hardwired: begin
            if (i == 2) begin
              pin_o[i]    <= prot_on;
              pin_oe_o[i] <= 1'b1;
            end
          end
          fn_event_in: pin_oe_o[i] <= 1'b0;
          fn_event_out: begin
            pin_oe_o[i] <= 1'b1;
            case (line_cfg[i].act)
              out_fixed_high_level:     pin_o[i] <= 1'b1;
              out_fixed_low_level:      pin_o[i] <= 1'b0;
              out_battery_full:         pin_o[i] <= battery_full_i ^ line_cfg[i].pol;
              out_battery_depleted:     pin_o[i] <= battery_depleted_i ^ line_cfg[i].pol;
              out_regulation_mode_flag: pin_o[i] <= regulation_mode_flag_i ^ line_cfg[i].pol;
              out_sequence_finished:    pin_o[i] <= sequence_done_i ^ line_cfg[i].pol;
              default:                  pin_o[i] <= source_state_flag_i ^ line_cfg[i].pol;
            endcase
          end
          default: begin
            if (line_cfg[i].act == sw_software_drive_high) begin
              pin_o[i]    <= 1'b1;
              pin_oe_o[i] <= 1'b1;
            end else if (line_cfg[i].act == sw_software_drive_low) begin
              pin_oe_o[i] <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  logic [35:0] cfg_flat;
  logic [5:0]  in_mask;
  logic [5:0]  in_mask_q;
  logic [9:0]  hi_cnt;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cfg_flat[i*6 +: 6] = line_cfg[i];
      in_mask[i] = (line_cfg[i].func == fn_event_in)
                   || (line_cfg[i].func == fn_hardwired && i == 0)
                   || (line_cfg[i].func == fn_software
                       && line_cfg[i].act == sw_software_read_pin);
    end
  end

  always_ff @(posedge core_clk_i) begin
    in_mask_q <= in_mask;
    hi_cnt    <= prot_on ? hi_cnt + 10'h001 : 10'h000;
  end

  a_reset_defaults: assert property ($past(srst_i) |-> cfg_flat == 36'h0_c30c_00c0)
    else $error("line defaults wrong after reset");
  a_hw_lines_only: assert property (line_cfg[1].func != fn_hardwired
    && line_cfg[3].func != fn_hardwired && line_cfg[4].func != fn_hardwired
    && line_cfg[5].func != fn_hardwired)
    else $error("hardwired function on a wrong line");
  a_trigger_rise: assert property (line_cfg[0].func == fn_hardwired
    && trig_sel == trig_rise && pin_rise[0] |=> trigger_pulse_o)
    else $error("line 1 rising edge not seen");
  a_pulse_width: assert property ($fell(prot_on) |-> hi_cnt == 10'h190)
    else $error("protection pulse not 10 us");
  a_evin_enable: assert property (line_cfg[4].func == fn_event_in
    && line_cfg[4].act == in_enable_source_output && line_cfg[4].pol == edge_rise
    && pin_rise[4] |=> in_pulse_o.enable_source_output)
    else $error("event input did not enable output");
  a_seq_gate: assert property (acc_w && cfg_hit && avl_i.byteenable[0]
    && wcfg.func == fn_event_in && wcfg.act == in_begin_sequence
    && op_mode != cell_tester_mode |=> reject)
    else $error("sequence input accepted outside cell tester mode");
  a_batt_gate: assert property (acc_w && cfg_hit && avl_i.byteenable[0]
    && wcfg.func == fn_event_out && wcfg.act == out_battery_full
    && op_mode != battery_emulation_mode |=> reject)
    else $error("battery output accepted outside emulation mode");
  a_cell_gate: assert property (acc_w && cfg_hit && avl_i.byteenable[0]
    && wcfg.func == fn_event_out && wcfg.act == out_regulation_mode_flag
    && op_mode != cell_tester_mode |=> reject)
    else $error("regulation output accepted outside cell tester mode");
  a_reject_hold: assert property (acc_w && cfg_hit && !cfg_ok |=> $stable(cfg_flat))
    else $error("rejected write changed a line");
  a_out_polarity: assert property (line_cfg[1].func == fn_event_out
    && line_cfg[1].act == out_source_state_flag && line_cfg[1].pol == edge_fall
    |=> pin_oe_o[1] && pin_o[1] == !$past(source_state_flag_i))
    else $error("falling polarity not applied");
  a_sw_drive: assert property (line_cfg[5].func == fn_software
    && line_cfg[5].act == sw_software_drive_high |=> pin_o[5] && pin_oe_o[5])
    else $error("software drive high not on pin");
  a_input_released: assert property (!$past(srst_i) |-> (in_mask_q & pin_oe_o) == 6'h00)
    else $error("input line is driven");

  c_reject: cover property (acc_w && cfg_hit && !cfg_ok);
  c_prot_pulse: cover property ($fell(prot_on));
  c_trigger: cover property (trigger_pulse_o);
  c_evin: cover property (in_pulse_o.halt_sequence);

endmodule

// ==== hw/dio_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the dio block
// Assumes: 40 MHz core clock, byte addresses on the register bus
// Notes:   definitions only
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define DIO_LINES     6
`define OFS_LINE_BASE 8'h00
`define OFS_LINE_LAST 8'h14
`define OFS_MODE      8'h18
`define OFS_PINS      8'h1c
`define OFS_STAT      8'h20

// ----------------------------------------
// fields
// ----------------------------------------
`define FLD_CFG_LSB   0
`define FLD_CFG_MSB   5
`define FLD_MODE_LSB  0
`define FLD_MODE_MSB  1
`define FLD_TRIG_LSB  2
`define FLD_TRIG_MSB  3
`define FLD_REJECT    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CFG_HW    6'h00
`define RST_CFG_SW    6'h03
`define RST_MODE      2'h0
`define RST_TRIG      2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ       40000
`define PULSE_NS      10000
`define PULSE_CYC     9'((`PULSE_NS * `CLK_KHZ) / 1000000)

`endif

// ==== hw/dio_pin_sync.sv ====
// Purpose: bring the six line pins into the core clock domain
// Assumes: pins are asynchronous to core_clk_i
// Notes:   a change is taken once the second and third stages agree
module dio_pin_sync (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic [5:0] pin_i,
  output logic      [5:0] stable_o
);

  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      s3 <= 6'h00;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per-bit agreement filter against one-cycle glitches at the third stage
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stable_o <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (s2[i] == s3[i]) begin
          stable_o[i] <= s3[i];
        end
      end
    end
  end

endmodule

// ==== hw/dio_pkg.sv ====
// Purpose: types shared by the dio block
// Assumes: nothing beyond the cfg header
// Notes:   action codes of value zero are the per-function defaults
package dio_pkg;

  // ----------------------------------------
  // line configuration
  // ----------------------------------------
  typedef enum logic [1:0] {
    fn_hardwired = 2'h0,
    fn_event_in  = 2'h1,
    fn_event_out = 2'h2,
    fn_software  = 2'h3
  } func_t;

  typedef enum logic {
    edge_rise = 1'h0,
    edge_fall = 1'h1
  } edge_t;

  typedef enum logic [2:0] {
    in_enable_source_output  = 3'h0,
    in_disable_source_output = 3'h1,
    in_begin_sequence        = 3'h2,
    in_halt_sequence         = 3'h3
  } in_act_t;

  typedef enum logic [2:0] {
    out_fixed_high_level      = 3'h0,
    out_fixed_low_level       = 3'h1,
    out_battery_full          = 3'h2,
    out_battery_depleted      = 3'h3,
    out_regulation_mode_flag  = 3'h4,
    out_sequence_finished     = 3'h5,
    out_source_state_flag     = 3'h6
  } out_act_t;

  typedef enum logic [2:0] {
    sw_software_read_pin   = 3'h0,
    sw_software_drive_high = 3'h1,
    sw_software_drive_low  = 3'h2
  } sw_act_t;

  typedef enum logic [1:0] {
    mode_plain             = 2'h0,
    battery_emulation_mode = 2'h1,
    cell_tester_mode       = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    trig_rise   = 2'h0,
    trig_fall   = 2'h1,
    trig_either = 2'h2
  } trig_sel_t;

  typedef struct packed {
    edge_t       pol;
    logic [2:0]  act;
    func_t       func;
  } line_cfg_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avl_req_t;

  typedef struct packed {
    logic enable_source_output;
    logic disable_source_output;
    logic begin_sequence;
    logic halt_sequence;
  } in_pulse_t;

endpackage

// ==== tb/digital_io_line_config_tb_top.sv ====
// Purpose: register-level tests of the six-line port
// Assumes: one wait cycle per bus access, pins settle within ten cycles
// Notes:   pulse counters run in a monitor beside the sequence
`include "dio_cfg.svh"
module digital_io_line_config_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dio_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  avl_req_t    avl;
  logic [31:0] rdata;
  logic        wreq;
  logic        prot, sense, bfull, sst, regf;
  logic [5:0]  pin_i, pin_o, pin_oe;
  logic [5:0]  drv_en, drv_lvl;
  logic        trig;
  in_pulse_t   inp;
  logic [31:0] q;
  int          miscompares = 0;
  int          n_tests = 0;
  int          trig_cnt = 0, en_cnt = 0, hlt_cnt = 0, plen = 0, plast = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  digital_io_line_config u_digital_io_line_config (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .avl_i(avl), .avl_readdata_o(rdata),
    .avl_waitrequest_o(wreq), .protection_trip_i(prot), .sense_reversed_i(sense),
    .battery_full_i(bfull), .battery_depleted_i(1'b0), .regulation_mode_flag_i(regf),
    .sequence_done_i(1'b0), .source_state_flag_i(sst), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe), .trigger_pulse_o(trig), .in_pulse_o(inp));
  dio_far_end u_dio_far_end (.core_clk_i(core_clk_i), .dev_pin_i(pin_o), .dev_oe_i(pin_oe),
    .drv_en_i(drv_en), .drv_lvl_i(drv_lvl), .line_o(pin_i));
  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (trig === 1'b1) trig_cnt++;
    if (inp.enable_source_output === 1'b1) en_cnt++;
    if (inp.halt_sequence === 1'b1) hlt_cnt++;
    if (pin_o[2] === 1'b1) plen++;
    else if (plen != 0) begin
      plast = plen;
      plen = 0;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // hold the request until waitrequest is sampled low; only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avl.read <= ~wr;
    avl.write <= wr;
    avl.address <= a;
    avl.writedata <= d;
    do begin
      @(posedge core_clk_i);
    end while (wreq !== 1'b0);
    q = rdata;
    avl.read <= 1'b0;
    avl.write <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  function automatic logic [7:0] ofs(input int n);
    return 8'((n - 1) * 4);
  endfunction
  task automatic cfg(input int n, input logic [5:0] v, input logic rej);
    logic [31:0] old;
    xfer(1'b0, ofs(n), 32'h0);
    old = q;
    xfer(1'b1, ofs(n), {26'h0, v});
    rchk(ofs(n), rej ? old : {26'h0, v});
    rchk(`OFS_STAT, {31'h0, rej});
    xfer(1'b1, `OFS_STAT, 32'h1);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    avl = '0;
    avl.byteenable = 4'h1;
    {prot, sense, bfull, sst, regf} = 5'h00;
    drv_en = 6'h31;
    drv_lvl = 6'h00;
    tick(12);
    srst_i <= 1'b0;
    for (int n = 1; n <= 6; n++) rchk(ofs(n), (n == 1 || n == 3) ? 32'h0 : 32'h3);
    chk(pin_oe, 6'h04);
    rchk(8'h40, 32'h0);
    $display("test reset done");
    cfg(2, 6'h00, 1'b1);
    cfg(1, 6'h01, 1'b1);
    cfg(3, 6'h02, 1'b1);
    cfg(2, 6'h09, 1'b1);
    cfg(5, 6'h12, 1'b1);
    cfg(4, 6'h0a, 1'b1);
    xfer(1'b1, `OFS_MODE, 32'h2);
    cfg(2, 6'h09, 1'b0);
    cfg(5, 6'h12, 1'b0);
    regf <= 1'b1;
    tick(3);
    chk({pin_oe[4], pin_o[4]}, 2'h3);
    regf <= 1'b0;
    cfg(4, 6'h0a, 1'b1);
    xfer(1'b1, `OFS_MODE, 32'h1);
    cfg(4, 6'h0a, 1'b0);
    bfull <= 1'b1;
    tick(3);
    chk({pin_oe[3], pin_o[3]}, 2'h3);
    $display("test legality done");
    cfg(6, 6'h07, 1'b0);
    tick(2);
    chk({pin_oe[5], pin_o[5]}, 2'h3);
    cfg(6, 6'h0b, 1'b0);
    tick(2);
    chk({pin_oe[5], pin_o[5]}, 2'h2);
    cfg(6, 6'h03, 1'b0);
    drv_lvl[5] <= 1'b1;
    tick(10);
    chk(pin_oe[5], 1'b0);
    // line 4 drives battery full high, line 2 floats and never settles
    rchk(`OFS_PINS, 32'h28);
    chk(q[5], 1'b1);
    cfg(2, 6'h02, 1'b0);
    tick(2);
    chk({pin_oe[1], pin_o[1]}, 2'h3);
    cfg(2, 6'h3a, 1'b0);
    sst <= 1'b1;
    tick(3);
    chk(pin_o[1], 1'b0);
    $display("test outputs done");
    // line 5 event input; equipment already drives it low, so no stray edge
    cfg(5, 6'h01, 1'b0);
    en_cnt = 0;
    drv_lvl[4] <= 1'b1;
    tick(10);
    chk(en_cnt, 1);
    cfg(5, 6'h21, 1'b0);
    en_cnt = 0;
    drv_lvl[4] <= 1'b0;
    tick(10);
    drv_lvl[4] <= 1'b1;
    tick(10);
    chk(en_cnt, 1);
    chk(pin_oe[4], 1'b0);
    for (int t = 0; t < 3; t++) begin
      xfer(1'b1, `OFS_MODE, 32'((t << 2) | 1));
      trig_cnt = 0;
      drv_lvl[0] <= 1'b1;
      tick(10);
      drv_lvl[0] <= 1'b0;
      tick(10);
      chk(trig_cnt, (t == 2) ? 2 : 1);
    end
    // halt input needs cell tester mode; pin is high, so only the rise counts
    xfer(1'b1, `OFS_MODE, 32'h2);
    cfg(5, 6'h0d, 1'b0);
    drv_lvl[4] <= 1'b0;
    tick(10);
    drv_lvl[4] <= 1'b1;
    tick(10);
    chk(hlt_cnt, 1);
    $display("test events done");
    prot <= 1'b1;
    tick(10);
    sense <= 1'b1;
    tick(500);
    chk(plast, 400);
    {prot, sense} <= 2'h0;
    plast = 0;
    tick(4);
    sense <= 1'b1;
    tick(500);
    chk(plast, 400);
    $display("test protection done");
    conclude();
  end
  initial begin
    tick(20000);
    miscompares++;
    conclude();
  end
endmodule

// ==== tb/dio_far_end.sv ====
// Purpose: equipment wired to the six lines
// Assumes: no pull resistors on the lines
// Notes:   an undriven line toggles, so the port filter holds its last settled level
module dio_far_end (
  input  wire logic       core_clk_i,
  input  wire logic [5:0] dev_pin_i,
  input  wire logic [5:0] dev_oe_i,
  input  wire logic [5:0] drv_en_i,
  input  wire logic [5:0] drv_lvl_i,
  output logic      [5:0] line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  initial line_o = 6'h00;
  always @(posedge core_clk_i) begin
    for (int b = 0; b < 6; b++) begin
      if (dev_oe_i[b]) begin
        line_o[b] <= dev_pin_i[b];
      end else if (drv_en_i[b]) begin
        line_o[b] <= drv_lvl_i[b];
      end else begin
        line_o[b] <= ~line_o[b];
      end
    end
  end
endmodule
